// ==== core/sstte_defines.vh ====
`ifndef SSTTE_DEFINES_VH
`define SSTTE_DEFINES_VH
// ----------------------------------------
// opcode match patterns
// ----------------------------------------
`define SSTTE_OPC_SUB_MASK 16'hf00f
`define SSTTE_OPC_SUB 16'h3008
`define SSTTE_OPC_SUBB 16'h300a
`define SSTTE_OPC_SUBTRACT_UNDERFLOW_CHECK_OP 16'h300b
`define SSTTE_OPC_SWAPB 16'h6008
`define SSTTE_OPC_SWAPW 16'h6009
`define SSTTE_OPC_TAS_MASK 16'hf0ff
`define SSTTE_OPC_TAS 16'h401b
`define SSTTE_OPC_TRAP_MASK 16'hff00
`define SSTTE_OPC_TRAP 16'hc300
// ----------------------------------------
// field positions and constants
// ----------------------------------------
`define SSTTE_RN_HI 11
`define SSTTE_RN_LO 8
`define SSTTE_RM_HI 7
`define SSTTE_RM_LO 4
`define SSTTE_IMM_HI 7
`define SSTTE_IMM_LO 0
`define SSTTE_TAS_BIT 7
`define SSTTE_STACK_REG 4'hf
`define SSTTE_WORD_STEP 32'h00000004
`define SSTTE_PC_STEP 32'h00000002
`define SSTTE_TAS_CYCLES 4
`define SSTTE_TRAP_CYCLES 8
`define SSTTE_PC_RESET 32'h00000000
`endif

// ==== core/sstte_alu.v ====
`timescale 1ns/1ps
`include "sstte_defines.vh"
module sstte_alu (
   // operands
   input wire [31:0] dest_val,
   input wire [31:0] src_val,
   input wire t_in,
   // results
   output wire [31:0] diff,
   output wire [31:0] diff_borrow,
   output wire borrow_out,
   output wire underflow,
   output wire [31:0] swap_byte,
   output wire [31:0] swap_word
);
   // ----------------------------------------
   // subtract paths
   // ----------------------------------------
   wire [32:0] stage1;
   wire [32:0] stage2;
   assign stage1 = {1'b0, dest_val} - {1'b0, src_val};
   assign stage2 = {1'b0, stage1[31:0]} - {32'h00000000, t_in};
   assign diff = stage1[31:0];
   assign diff_borrow = stage2[31:0];
   // either stage borrowing sets the flag, so wide chains work
   assign borrow_out = stage1[32] | stage2[32];
   // opposite operand signs and result sign flipped from dest
   assign underflow = (dest_val[31] ^ src_val[31]) & (diff[31] ^ dest_val[31]);
   // ----------------------------------------
   // swap paths
   // ----------------------------------------
   assign swap_byte = {src_val[31:16], src_val[7:0], src_val[15:8]};
   assign swap_word = {src_val[15:0], src_val[31:16]};
endmodule

// ==== core/sstte_regfile.v ====
`timescale 1ns/1ps
module sstte_regfile #(
   parameter NREGS = 16,
   parameter AW = 4
) (
   // clock and reset
   input wire clk,
   input wire rst_b,
   // read ports, combinational
   input wire [AW-1:0] rd_a_sel,
   input wire [AW-1:0] rd_b_sel,
   output wire [31:0] rd_a,
   output wire [31:0] rd_b,
   // write port
   input wire wr_en,
   input wire [AW-1:0] wr_sel,
   input wire [31:0] wr_data
);
   reg [31:0] regs [0:NREGS-1];
   integer i;
   // general registers, cleared at reset
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (i = 0; i < NREGS; i = i + 1) begin
            regs[i] <= 32'h00000000;
         end
      end else if (wr_en) begin
         regs[wr_sel] <= wr_data;
      end
   end
   // async read keeps single-cycle ops to one edge
   assign rd_a = regs[rd_a_sel];
   assign rd_b = regs[rd_b_sel];
endmodule

// ==== core/sstte_exec.v ====
`timescale 1ns/1ps
`include "sstte_defines.vh"
// Overview of operation
// - sub opcode writes destination minus source in one cycle, flag kept.
// - borrow-subtract takes source and flag from destination, borrow into flag.
// - flag set if either subtraction stage borrows, else cleared.
// - underflow-check subtract writes difference, flag reports signed underflow, one cycle.
// - underflow only when operand signs differ and result sign differs from destination.
// - byte swap exchanges low two bytes, upper half copied unchanged.
// - word swap exchanges the two halves of the source.
// - test-set reads byte, flag is zero test, writes back bit 7 set, 4 cycles.
// - bus stays locked from test-set read through its write-back.
// - trap starts exception processing, 8 cycles, flag untouched.
// - vector address is immediate times four plus vector base; read longword target.
// - trap pushes status word then return address, stack down four each.
// - pushed return address is start of the instruction after the trap.
module sstte_exec (
   // clock and reset
   input wire clk,
   input wire rst_b,
   // instruction issue
   input wire instr_valid,
   input wire [15:0] instr,
   output wire instr_ready,
   output wire instr_done,
   output wire illegal,
   // processor state
   input wire [31:0] vector_base_register,
   input wire [31:0] processor_status_word,
   output reg t_flag,
   output reg [31:0] pc,
   // memory bus
   output reg mem_req,
   output reg mem_we,
   output reg [1:0] mem_size,
   output reg [31:0] mem_addr,
   output reg [31:0] mem_wdata,
   output reg mem_lock,
   input wire mem_ack,
   input wire [31:0] mem_rdata
);
   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam ST_IDLE = 8'h01;
   localparam ST_TRD = 8'h02;
   localparam ST_TWR = 8'h04;
   localparam ST_TPAD = 8'h08;
   localparam ST_PSW = 8'h10;
   localparam ST_PPC = 8'h20;
   localparam ST_VEC = 8'h40;
   localparam ST_XPAD = 8'h80;
   localparam SZ_BYTE = 2'h0;
   localparam SZ_LONG = 2'h2;

   reg [7:0] state;
   reg [7:0] next_state;
   reg [3:0] cyc;
   reg [3:0] op_reg;
   reg [31:0] vec_target;
   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire is_sub = (instr & `SSTTE_OPC_SUB_MASK) == `SSTTE_OPC_SUB;
   wire is_subb = (instr & `SSTTE_OPC_SUB_MASK) == `SSTTE_OPC_SUBB;
   wire is_subtract_underflow_check_op = (instr & `SSTTE_OPC_SUB_MASK) == `SSTTE_OPC_SUBTRACT_UNDERFLOW_CHECK_OP;
   wire is_swb = (instr & `SSTTE_OPC_SUB_MASK) == `SSTTE_OPC_SWAPB;
   wire is_sww = (instr & `SSTTE_OPC_SUB_MASK) == `SSTTE_OPC_SWAPW;
   wire is_tas = (instr & `SSTTE_OPC_TAS_MASK) == `SSTTE_OPC_TAS;
   wire is_trap = (instr & `SSTTE_OPC_TRAP_MASK) == `SSTTE_OPC_TRAP;
   wire single = is_sub | is_subb | is_subtract_underflow_check_op | is_swb | is_sww;
   wire idle = state == ST_IDLE;
   wire take = instr_valid & idle;
   wire [3:0] rn_sel = take ? instr[`SSTTE_RN_HI:`SSTTE_RN_LO] : op_reg;
   wire [3:0] rm_sel = instr[`SSTTE_RM_HI:`SSTTE_RM_LO];
   wire [7:0] imm = instr[`SSTTE_IMM_HI:`SSTTE_IMM_LO];
   wire [31:0] dest_val;
   wire [31:0] src_val;
   wire [31:0] sp_val;
   wire [31:0] diff;
   wire [31:0] diff_borrow;
   wire borrow_out;
   wire underflow;
   wire [31:0] swap_byte;
   wire [31:0] swap_word;

   assign instr_ready = idle;
   assign illegal = take & ~(single | is_tas | is_trap);

   sstte_alu u_alu (
      .dest_val(dest_val),
      .src_val(src_val),
      .t_in(t_flag),
      .diff(diff),
      .diff_borrow(diff_borrow),
      .borrow_out(borrow_out),
      .underflow(underflow),
      .swap_byte(swap_byte),
      .swap_word(swap_word)
   );
   // ----------------------------------------
   // register file write selection
   // ----------------------------------------
   reg rf_we;
   reg [3:0] rf_sel;
   reg [31:0] rf_data;
   // a trap reads the stack pointer at take, so the first push address is ready at once
   wire [3:0] rd_b_sel = (idle & ~is_trap) ? rm_sel : `SSTTE_STACK_REG;
   assign sp_val = src_val;

   sstte_regfile #(
      .NREGS(16),
      .AW(4)
   ) u_rf (
      .clk(clk),
      .rst_b(rst_b),
      .rd_a_sel(rn_sel),
      .rd_b_sel(rd_b_sel),
      .rd_a(dest_val),
      .rd_b(src_val),
      .wr_en(rf_we),
      .wr_sel(rf_sel),
      .wr_data(rf_data)
   );

   // single-cycle results and stack pointer updates
   always @* begin
      rf_we = 1'b0;
      rf_sel = rn_sel;
      rf_data = diff;
      if (take & is_sub) begin
         rf_we = 1'b1;
      end else if (take & is_subb) begin
         rf_we = 1'b1;
         rf_data = diff_borrow;
      end else if (take & is_subtract_underflow_check_op) begin
         rf_we = 1'b1;
      end else if (take & is_swb) begin
         rf_we = 1'b1;
         rf_data = swap_byte;
      end else if (take & is_sww) begin
         rf_we = 1'b1;
         rf_data = swap_word;
      end else if ((state == ST_PSW || state == ST_PPC) && mem_ack) begin
         rf_we = 1'b1;
         rf_sel = `SSTTE_STACK_REG;
         rf_data = sp_val - `SSTTE_WORD_STEP;
      end
   end
   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   // bus steps wait on ack; padding states make up the documented count
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (take & is_tas) next_state = ST_TRD;
            else if (take & is_trap) next_state = ST_PSW;
         end
         ST_TRD: if (mem_ack) next_state = ST_TWR;
         ST_TWR: if (mem_ack) next_state = ST_TPAD;
         ST_TPAD: if (cyc >= `SSTTE_TAS_CYCLES - 1) next_state = ST_IDLE;
         ST_PSW: if (mem_ack) next_state = ST_PPC;
         ST_PPC: if (mem_ack) next_state = ST_VEC;
         ST_VEC: if (mem_ack) next_state = ST_XPAD;
         ST_XPAD: if (cyc >= `SSTTE_TRAP_CYCLES - 1) next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   assign instr_done = (take & single) |
                       (state == ST_TPAD && next_state == ST_IDLE) |
                       (state == ST_XPAD && next_state == ST_IDLE);

   // state, cycle count, flag, program counter and bus drive
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_IDLE;
         cyc <= 4'h0;
         op_reg <= 4'h0;
         t_flag <= 1'b0;
         pc <= `SSTTE_PC_RESET;
         vec_target <= 32'h00000000;
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_size <= SZ_BYTE;
         mem_addr <= 32'h00000000;
         mem_wdata <= 32'h00000000;
         mem_lock <= 1'b0;
      end else begin
         state <= next_state;
         cyc <= (next_state == ST_IDLE) ? 4'h0 : cyc + 4'h1;
         if (take) begin
            op_reg <= instr[`SSTTE_RN_HI:`SSTTE_RN_LO];
         end
         if (take & single) begin
            pc <= pc + `SSTTE_PC_STEP;
            if (is_subb) t_flag <= borrow_out;
            else if (is_subtract_underflow_check_op) t_flag <= underflow;
         end
         if (take & is_tas) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_size <= SZ_BYTE;
            mem_addr <= dest_val;
            mem_lock <= 1'b1;
         end
         if (state == ST_TRD && mem_ack) begin
            t_flag <= (mem_rdata[7:0] == 8'h00);
            mem_we <= 1'b1;
            mem_wdata <= {24'h000000, mem_rdata[7:0] | 8'h80};
         end
         if (state == ST_TWR && mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_lock <= 1'b0;
            pc <= pc + `SSTTE_PC_STEP;
         end
         if (take & is_trap) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_size <= SZ_LONG;
            mem_addr <= sp_val - `SSTTE_WORD_STEP;
            mem_wdata <= processor_status_word;
            vec_target <= vector_base_register + {22'h000000, imm, 2'h0};
         end
         if (state == ST_PSW && mem_ack) begin
            mem_addr <= sp_val - `SSTTE_WORD_STEP - `SSTTE_WORD_STEP;
            mem_wdata <= pc + `SSTTE_PC_STEP;
         end
         if (state == ST_PPC && mem_ack) begin
            mem_we <= 1'b0;
            mem_addr <= vec_target;
         end
         if (state == ST_VEC && mem_ack) begin
            mem_req <= 1'b0;
            pc <= mem_rdata;
         end
      end
   end
endmodule

// ==== bench/sstte_exec_monitor.sv ====
`timescale 1ns/1ps
`include "sstte_defines.vh"
// ----------
// exec checker
// ----------
module sstte_exec_monitor (
   // issue side
   input wire clk,
   input wire rst_b,
   input wire instr_valid,
   input wire [15:0] instr,
   input wire instr_ready,
   input wire instr_done,
   // state and bus
   input wire t_flag,
   input wire [31:0] pc,
   input wire mem_req,
   input wire mem_we,
   input wire [1:0] mem_size,
   input wire [31:0] mem_wdata,
   input wire mem_lock,
   input wire mem_ack,
   input wire [31:0] mem_rdata
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // decode; long reads only come from the trap vector fetch
   wire tk = instr_valid && instr_ready;
   wire [15:0] ar = instr & `SSTTE_OPC_SUB_MASK;
   wire one = ar == `SSTTE_OPC_SUB || ar == `SSTTE_OPC_SUBB || ar == `SSTTE_OPC_SUBTRACT_UNDERFLOW_CHECK_OP
      || ar == `SSTTE_OPC_SWAPB || ar == `SSTTE_OPC_SWAPW;
   wire trap = (instr & `SSTTE_OPC_TRAP_MASK) == `SSTTE_OPC_TRAP;
   wire rd = mem_req && !mem_we && mem_ack;
   property p_one; tk && one |-> instr_done; endproperty
   property p_pc; tk && one |=> pc == $past(pc) + 32'h2; endproperty
   property p_sub; tk && ar == `SSTTE_OPC_SUB |=> $stable(t_flag); endproperty
   property p_lock; mem_lock && !(mem_we && mem_ack) |=> mem_lock; endproperty
   property p_twr; mem_lock && mem_req && mem_we |-> mem_wdata[7] && mem_size == 2'h0; endproperty
   property p_tt; mem_lock && rd |=> t_flag == (($past(mem_rdata) & 32'hff) == 32'h0); endproperty
   property p_trt; tk && trap |=> $stable(t_flag) [*7]; endproperty
   property p_trd; tk && trap |-> ##[7:80] instr_done; endproperty
   property p_vec; !mem_lock && rd && mem_size == 2'h2 |=> pc == $past(mem_rdata); endproperty
   property p_tsz; mem_req && mem_we && !mem_lock |-> mem_size == 2'h2; endproperty
   property p_trs; tk && trap |=> !instr_done [*6]; endproperty
   a_one: assert property (p_one) else $error("single op not done at take");
   a_pc: assert property (p_pc) else $error("bad pc step");
   a_sub: assert property (p_sub) else $error("flag moved on subtract");
   a_lock: assert property (p_lock) else $error("lock dropped early");
   a_twr: assert property (p_twr) else $error("bad test-set write");
   a_tt: assert property (p_tt) else $error("bad test-set flag");
   a_trt: assert property (p_trt) else $error("flag moved in trap");
   a_trd: assert property (p_trd) else $error("trap too short or hung");
   a_vec: assert property (p_vec) else $error("vector not loaded");
   a_tsz: assert property (p_tsz) else $error("trap push not a longword");
   a_trs: assert property (p_trs) else $error("trap finished too soon");
   c_trap: cover property (tk && trap);
   c_tas: cover property (mem_lock && rd);
   c_subb: cover property (tk && ar == `SSTTE_OPC_SUBB);
endmodule
bind sstte_exec sstte_exec_monitor u_mon (.*);

// ==== bench/sstte_mem_model.sv ====
`timescale 1ns/1ps
// ----------
// memory partner
// ----------
module sstte_mem_model (
   // request
   input wire clk,
   input wire rst_b,
   input wire mem_req,
   input wire mem_we,
   input wire [1:0] mem_size,
   input wire [31:0] mem_addr,
   input wire [31:0] mem_wdata,
   // answer
   output reg mem_ack,
   output reg [31:0] mem_rdata
);
   logic [31:0] mem [logic [31:0]];
   logic [31:0] sd = 32'h0000beef;
   logic [31:0] w;
   logic [1:0] wait_n;
   // random 0..3 wait; no ack right after one, the request is still old
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mem_ack <= 1'b0;
         wait_n <= 2'h0;
      end else begin
         sd = sd ^ (sd << 13);
         sd = sd ^ (sd >> 17);
         sd = sd ^ (sd << 5);
         mem_ack <= 1'b0;
         mem_rdata <= sd; // churns so stale data is caught
         if (mem_req && !mem_ack && wait_n != 2'h0) begin
            wait_n <= wait_n - 2'h1;
         end else if (mem_req && !mem_ack) begin
            mem_ack <= 1'b1;
            wait_n <= sd[1:0];
            w = mem_addr ^ 32'h00a50000;
            if (mem_size == 2'h0) w = 32'h0;
            if (mem.exists(mem_addr)) w = mem[mem_addr];
            if (mem_we) mem[mem_addr] = mem_size == 2'h0 ? {24'h0, mem_wdata[7:0]} : mem_wdata;
            else mem_rdata <= mem_size == 2'h0 ? {4{w[7:0]}} : w;
         end
      end
   end
endmodule

// ==== bench/sstte_exec_tb.sv ====
`timescale 1ns/1ps
// ----------
// exec testbench
// ----------
module sstte_exec_tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic instr_valid = 1'b0;
   logic [15:0] instr = 16'h0;
   logic [31:0] vector_base_register = 32'h0;
   logic [31:0] processor_status_word = 32'h0;
   wire instr_ready, instr_done, illegal, t_flag, mem_req, mem_we, mem_lock, mem_ack;
   wire [1:0] mem_size;
   wire [31:0] pc, mem_addr, mem_wdata, mem_rdata;
   int fail_count = 0;
   int comparisons = 0;
   logic [31:0] rng = 32'd38279;
   logic [31:0] r [16] = '{default: 32'h0};
   logic t = 1'b0;
   logic [31:0] pc_m = 32'h0;
   logic [31:0] bm [logic [31:0]];
   logic [64:0] bus_q [$];
   sstte_exec dut (.*);
   sstte_mem_model mem (.*);
   // clock, and a log of every answered access
   always #12.5 clk = ~clk;
   always @(posedge clk) if (mem_req === 1'b1 && mem_ack) bus_q.push_back({mem_we, mem_addr, mem_wdata});
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   task automatic stop_test();
      if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // bounded wait at negedges for ready or done
   task automatic wt(input logic want_done);
      for (int i = 0; i < 100; i++) begin
         if ((want_done ? instr_done : instr_ready) === 1'b1) return;
         @(negedge clk);
      end
      fail_count++;
      stop_test();
   endtask
   // offer one opcode; the model steps at the take edge, state is
   // compared at the start of the next offer so single ops run back to back
   task automatic issue(input logic [15:0] op);
      logic [3:0] n;
      logic [3:0] m;
      logic [32:0] d;
      logic [31:0] a;
      logic [64:0] e [$];
      n = op[11:8];
      m = op[7:4];
      instr_valid <= 1'b1;
      instr <= op;
      @(negedge clk);
      check({31'h0, t_flag}, {31'h0, t});
      check(pc, pc_m);
      wt(1'b0);
      if (op[15:13] != 3'h6 && op[15:12] != 4'h4) check({31'h0, instr_done | illegal}, 32'h1);
      @(posedge clk);
      casez (op)
         16'b0011????????1000: r[n] = r[n] - r[m];
         16'b0110????????1000: r[n] = {r[m][31:16], r[m][7:0], r[m][15:8]};
         16'b0110????????1001: r[n] = {r[m][15:0], r[m][31:16]};
         16'b0011????????1010: begin
            d = {1'b0, r[n]} - {1'b0, r[m]} - {32'h0, t};
            r[n] = d[31:0];
            t = d[32];
         end
         16'b0011????????1011: begin
            a = r[n] - r[m];
            t = r[n][31] != r[m][31] && a[31] != r[n][31];
            r[n] = a;
         end
         16'b0100????00011011: begin
            d = bm.exists(r[n]) ? {1'b0, bm[r[n]]} : 33'h0;
            t = d[7:0] == 8'h00;
            bm[r[n]] = {24'h0, d[7:0] | 8'h80};
            e = '{{1'b0, r[n], 32'h0}, {1'b1, r[n], bm[r[n]]}};
         end
         16'b11000011????????: begin
            a = r[15] - 32'h4;
            bm[a] = processor_status_word;
            bm[a - 32'h4] = pc_m + 32'h2;
            r[15] = a - 32'h8 + 32'h4;
            e = '{{1'b1, a, processor_status_word}, {1'b1, r[15], pc_m + 32'h2}};
            a = vector_base_register + {22'h0, op[7:0], 2'b00};
            e.push_back({1'b0, a, 32'h0});
            pc_m = bm.exists(a) ? bm[a] : a ^ 32'h00a50000;
         end
         default: pc_m = pc_m - 32'h2;
      endcase
      if (op[15:14] != 2'b11) pc_m = pc_m + 32'h2;
      if (e.size() != 0) begin
         instr_valid <= 1'b0;
         @(negedge clk);
         wt(1'b1);
         @(posedge clk);
         check(bus_q.size(), e.size());
         foreach (e[i]) begin
            check(bus_q[i][63:32], e[i][63:32]);
            check({31'h0, bus_q[i][64]}, {31'h0, e[i][64]});
            if (e[i][64]) check(bus_q[i][31:0] & (op[15] ? 32'hffffffff : 32'hff), e[i][31:0]);
         end
         bus_q.delete();
      end
   endtask
   // random mix of every opcode of the group plus an outsider
   initial begin
      logic [31:0] x;
      logic [15:0] op;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      issue(16'h401b);
      repeat (400) begin
         x = rnd();
         vector_base_register <= rnd();
         processor_status_word <= rnd();
         case (x[18:16])
            3'h0: op = {4'h3, x[11:4], 4'h8};
            3'h1: op = {4'h3, x[11:4], 4'ha};
            3'h2: op = {4'h3, x[11:4], 4'hb};
            3'h3: op = {4'h6, x[11:4], 4'h8};
            3'h4: op = {4'h6, x[11:4], 4'h9};
            3'h5: op = {4'h4, x[11:8], 8'h1b};
            3'h6: op = {8'hc3, x[7:0]};
            default: op = 16'h0009;
         endcase
         issue(op);
      end
      issue(16'h0009);
      stop_test();
   end
endmodule
